// File: common/dis_pkg.sv
package dis_pkg;
    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int DEB_LONG_MS = 3;
    localparam int DEB_SHORT_MS = 1;
    localparam int DEB_LONG_CYC = DEB_LONG_MS * (CLK_HZ / 1000);
    localparam int DEB_SHORT_CYC = DEB_SHORT_MS * (CLK_HZ / 1000);
    localparam int DEB_CNT_W = 20;

    // ****************************************
    // Serial word layout
    // ****************************************
    localparam int CHANNELS = 8;
    localparam int WORD_BITS = 11;
    localparam int POS_CHECK = 10;
    localparam int POS_SUPPLY = 9;
    localparam int POS_HOT = 8;
    localparam int POS_LAST_CH = 0;
    localparam logic [3:0] SHIFT_FULL = 4'hb;

    // ****************************************
    // Register offsets and reset values
    // ****************************************
    localparam logic [7:0] OFS_STATE = 8'h00;
    localparam logic [7:0] OFS_INT_STAT = 8'h04;
    localparam logic [7:0] OFS_INT_MASK = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h0c;
    localparam logic [7:0] OFS_CAPTURE = 8'h10;
    localparam logic [7:0] OFS_SHIFT_WORD = 8'h14;
    localparam logic [5:0] INT_MASK_RST = 6'h00;
    localparam logic [2:0] CTRL_RST = 3'h0;
    // Idle pin levels: selects open, strobe and enable high
    localparam logic [16:0] PIN_IDLE = 17'h0018a;

    // ****************************************
    // Control and interrupt fields
    // ****************************************
    localparam int CTRL_OVR = 0;
    localparam int CTRL_SEL_LO = 1;
    localparam int CTRL_SEL_HI = 2;
    localparam int INT_W = 6;
    localparam int INT_CAPTURE = 0;
    localparam int INT_DRAINED = 1;
    localparam int INT_CHANGE = 2;
    localparam int INT_HOT = 3;
    localparam int INT_SHUTDOWN = 4;
    localparam int INT_SUPPLY = 5;

    // ****************************************
    // Link sequence states
    // ****************************************
    typedef enum logic [1:0] {
        DIS_IDLE = 2'b00,
        DIS_LOAD = 2'b01,
        DIS_SHIFT = 2'b11,
        DIS_DRAINED = 2'b10
    } dis_state_t;
endpackage

// File: common/dis_shreg_if.sv
`timescale 1ns/1ps
interface dis_shreg_if;
    logic load_n;
    logic shift;
    logic ser_in;
    logic [10:0] par_word;
    logic [10:0] word;

    modport ctrl
    (
        output load_n,
        output shift,
        output ser_in,
        output par_word,
        input word
    );
    modport reg_side
    (
        input load_n,
        input shift,
        input ser_in,
        input par_word,
        output word
    );
endinterface

// File: src/dis_debounce.sv
`timescale 1ns/1ps
module dis_debounce #(
    parameter int N = 8,
    parameter int LONG_CYC = 300000,
    parameter int SHORT_CYC = 100000
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Select levels, high means pin left open
    input wire logic sel_low_i,
    input wire logic sel_high_i,
    // Raw and filtered channels
    input wire logic [N-1:0] raw_i,
    output logic [N-1:0] stable_o
);
    localparam int CW = dis_pkg::DEB_CNT_W;

    logic [CW-1:0] cnt_reg [N];
    logic [CW-1:0] limit;
    logic bypass;

    // ****************************************
    // Interval select
    // ****************************************
    // Reserved select falls back to the long interval: safest choice
    always_comb
    begin
        bypass = 1'b0;
        limit = CW'(LONG_CYC - 1);
        if (sel_high_i && !sel_low_i)
            limit = CW'(SHORT_CYC - 1);
        else if (!sel_high_i && sel_low_i)
            bypass = 1'b1;
    end

    // ****************************************
    // Per channel persistence counters
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stable_o <= '0;
            for (int i = 0; i < N; i++)
                cnt_reg[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < N; i++)
            begin
                if (bypass || raw_i[i] == stable_o[i])
                begin
                    stable_o[i] <= raw_i[i];
                    cnt_reg[i] <= '0;
                end
                else if (cnt_reg[i] >= limit)
                begin
                    stable_o[i] <= raw_i[i];
                    cnt_reg[i] <= '0;
                end
                else
                    cnt_reg[i] <= cnt_reg[i] + 1'b1;
            end
        end
    end
endmodule

// File: src/dis_shreg.sv
`timescale 1ns/1ps
module dis_shreg
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control and data
    dis_shreg_if.reg_side sr
);
    logic [10:0] word_reg;

    assign sr.word = word_reg;

    // ****************************************
    // Load, shift or hold
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            word_reg <= '0;
        else if (!sr.load_n)
            word_reg <= sr.par_word;
        else if (sr.shift)
            word_reg <= {word_reg[9:0], sr.ser_in};
        // Otherwise hold
    end
endmodule

// File: src/dis_top.sv
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module dis_top #(
    parameter int DEB_LONG_CYC = dis_pkg::DEB_LONG_CYC,
    parameter int DEB_SHORT_CYC = dis_pkg::DEB_SHORT_CYC
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Field side pins
    input wire logic [7:0] field_channel_i,
    input wire logic filter_select_low_i,
    input wire logic filter_select_high_i,
    // Status sensors
    input wire logic low_supply_flag_i,
    input wire logic temp_trip_i,
    input wire logic temp_shutdown_i,
    // Serial link pins
    input wire logic capture_strobe_n_i,
    input wire logic shift_clk_i,
    input wire logic shift_enable_n_i,
    input wire logic chain_in_i,
    output logic chain_out_o,
    output logic chain_out_oe_o,
    // Overtemperature pin
    output logic overtemp_flag_n_o,
    output logic overtemp_flag_n_oe_o,
    // Interrupt
    output logic irq_o
);
    localparam int NP = 17;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [NP-1:0] pin_meta_reg;
    logic [NP-1:0] pin_sync_reg;
    logic clk_seen_reg;

    always_ff @(posedge clk_i)
    begin
        // Idle levels in reset, so no false load follows release
        if (rst_i)
        begin
            pin_meta_reg <= dis_pkg::PIN_IDLE;
            pin_sync_reg <= dis_pkg::PIN_IDLE;
        end
        else
        begin
            pin_meta_reg <= {field_channel_i, filter_select_low_i,
                filter_select_high_i, low_supply_flag_i, temp_trip_i,
                temp_shutdown_i, capture_strobe_n_i, shift_clk_i,
                shift_enable_n_i, chain_in_i};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    logic [7:0] ch_raw;
    logic sel_low_s;
    logic sel_high_s;
    logic supply_s;
    logic hot_s;
    logic shd_s;
    logic strobe_n_s;
    logic sclk_s;
    logic sen_n_s;
    logic chain_s;

    assign ch_raw = pin_sync_reg[16:9];
    assign sel_low_s = pin_sync_reg[8];
    assign sel_high_s = pin_sync_reg[7];
    assign supply_s = pin_sync_reg[6];
    assign hot_s = pin_sync_reg[5];
    assign shd_s = pin_sync_reg[4];
    assign strobe_n_s = pin_sync_reg[3];
    assign sclk_s = pin_sync_reg[2];
    assign sen_n_s = pin_sync_reg[1];
    assign chain_s = pin_sync_reg[0];

    // Third stage only for edge finding; the link clock is sampled
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            clk_seen_reg <= 1'b0;
        else
            clk_seen_reg <= sclk_s;
    end

    logic sclk_rise;
    assign sclk_rise = sclk_s && !clk_seen_reg;

    // ****************************************
    // Control register and filter
    // ****************************************
    logic [2:0] ctrl_reg;
    logic sel_low_eff;
    logic sel_high_eff;
    logic [7:0] ch_stable;

    assign sel_low_eff = ctrl_reg[dis_pkg::CTRL_OVR]
        ? ctrl_reg[dis_pkg::CTRL_SEL_LO] : sel_low_s;
    assign sel_high_eff = ctrl_reg[dis_pkg::CTRL_OVR]
        ? ctrl_reg[dis_pkg::CTRL_SEL_HI] : sel_high_s;

    dis_debounce #(
        .N(dis_pkg::CHANNELS),
        .LONG_CYC(DEB_LONG_CYC),
        .SHORT_CYC(DEB_SHORT_CYC)
    ) u_deb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_low_i(sel_low_eff),
        .sel_high_i(sel_high_eff),
        .raw_i(ch_raw),
        .stable_o(ch_stable)
    );

    // ****************************************
    // Parallel word with check bit
    // ****************************************
    function automatic logic [10:0] dis_pack(input logic [7:0] ch,
                                             input logic sup,
                                             input logic hot_n);
        logic [10:0] w;
        w = '0;
        for (int i = 0; i < dis_pkg::CHANNELS; i++)
            w[dis_pkg::POS_LAST_CH + 7 - i] = ch[i];
        w[dis_pkg::POS_SUPPLY] = sup;
        w[dis_pkg::POS_HOT] = hot_n;
        w[dis_pkg::POS_CHECK] = ~^w[9:0];
        return w;
    endfunction

    logic [10:0] par_word_reg;

    // Rebuilt every cycle, so any status change refreshes the check bit
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            par_word_reg <= dis_pack('0, 1'b0, 1'b1);
        else
            par_word_reg <= dis_pack(ch_stable, supply_s, !hot_s);
    end

    // ****************************************
    // Shift register
    // ****************************************
    dis_shreg_if sr();

    assign sr.load_n = strobe_n_s;
    assign sr.shift = strobe_n_s && !sen_n_s && sclk_rise;
    assign sr.ser_in = chain_s;
    assign sr.par_word = par_word_reg;

    dis_shreg u_sr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sr(sr)
    );

    // ****************************************
    // Link sequence tracking
    // ****************************************
    dis_pkg::dis_state_t state_reg;
    logic [3:0] shift_cnt_reg;
    logic [10:0] capture_reg;
    logic ev_capture;
    logic ev_drained;

    assign ev_capture = (state_reg == dis_pkg::DIS_LOAD) && strobe_n_s;
    assign ev_drained = (state_reg == dis_pkg::DIS_SHIFT) && sr.shift
        && (shift_cnt_reg == dis_pkg::SHIFT_FULL - 4'h1);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state_reg <= dis_pkg::DIS_IDLE;
        else if (!strobe_n_s)
            state_reg <= dis_pkg::DIS_LOAD;
        else
        begin
            case (state_reg)
                dis_pkg::DIS_IDLE:
                    state_reg <= dis_pkg::DIS_IDLE;
                dis_pkg::DIS_LOAD:
                    state_reg <= dis_pkg::DIS_SHIFT;
                dis_pkg::DIS_SHIFT:
                    if (ev_drained)
                        state_reg <= dis_pkg::DIS_DRAINED;
                dis_pkg::DIS_DRAINED:
                    state_reg <= dis_pkg::DIS_DRAINED;
                default:
                    state_reg <= dis_pkg::DIS_IDLE;
            endcase
        end
    end

    // Counter saturates; cascaded words keep shifting through
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !strobe_n_s)
            shift_cnt_reg <= '0;
        else if (sr.shift && shift_cnt_reg != dis_pkg::SHIFT_FULL)
            shift_cnt_reg <= shift_cnt_reg + 4'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            capture_reg <= '0;
        else if (ev_capture)
            capture_reg <= sr.word;
    end

    // ****************************************
    // Pin outputs
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            chain_out_o <= 1'b0;
            chain_out_oe_o <= 1'b0;
            overtemp_flag_n_o <= 1'b1;
            overtemp_flag_n_oe_o <= 1'b0;
        end
        else
        begin
            chain_out_o <= sr.word[dis_pkg::POS_CHECK];
            chain_out_oe_o <= !shd_s;
            overtemp_flag_n_o <= !hot_s;
            overtemp_flag_n_oe_o <= !shd_s;
        end
    end

    // ****************************************
    // Event detection
    // ****************************************
    logic [7:0] ch_prev_reg;
    logic hot_prev_reg;
    logic shd_prev_reg;
    logic sup_prev_reg;
    logic [5:0] events;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ch_prev_reg <= '0;
            hot_prev_reg <= 1'b0;
            shd_prev_reg <= 1'b0;
            sup_prev_reg <= 1'b0;
        end
        else
        begin
            ch_prev_reg <= ch_stable;
            hot_prev_reg <= hot_s;
            shd_prev_reg <= shd_s;
            sup_prev_reg <= supply_s;
        end
    end

    always_comb
    begin
        events = '0;
        events[dis_pkg::INT_CAPTURE] = ev_capture;
        events[dis_pkg::INT_DRAINED] = ev_drained;
        events[dis_pkg::INT_CHANGE] = ch_stable != ch_prev_reg;
        events[dis_pkg::INT_HOT] = hot_s && !hot_prev_reg;
        events[dis_pkg::INT_SHUTDOWN] = shd_s && !shd_prev_reg;
        events[dis_pkg::INT_SUPPLY] = supply_s != sup_prev_reg;
    end

    // ****************************************
    // Wishbone slave
    // ****************************************
    logic [5:0] int_stat_reg;
    logic [5:0] int_mask_reg;
    logic bus_req;
    logic wr_stb;
    logic [31:0] rd_data;

    // One wait state: ack is registered and drops after one cycle
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_stb = bus_req && wb_we_i && wb_sel_i[0];

    always_comb
    begin
        rd_data = '0;
        case (wb_adr_i)
            dis_pkg::OFS_STATE:
                rd_data = {14'h0000, shift_cnt_reg, state_reg,
                    par_word_reg[dis_pkg::POS_CHECK], shd_s, hot_s,
                    supply_s, ch_stable};
            dis_pkg::OFS_INT_STAT:
                rd_data = {26'h0000000, int_stat_reg};
            dis_pkg::OFS_INT_MASK:
                rd_data = {26'h0000000, int_mask_reg};
            dis_pkg::OFS_CTRL:
                rd_data = {29'h00000000, ctrl_reg};
            dis_pkg::OFS_CAPTURE:
                rd_data = {21'h000000, capture_reg};
            dis_pkg::OFS_SHIFT_WORD:
                rd_data = {21'h000000, sr.word};
            default:
                rd_data = '0;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_data : '0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_reg <= dis_pkg::CTRL_RST;
            int_mask_reg <= dis_pkg::INT_MASK_RST;
        end
        else if (wr_stb)
        begin
            if (wb_adr_i == dis_pkg::OFS_CTRL)
                ctrl_reg <= wb_dat_i[2:0];
            if (wb_adr_i == dis_pkg::OFS_INT_MASK)
                int_mask_reg <= wb_dat_i[5:0];
        end
    end

    // New events win over a write-one clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            int_stat_reg <= '0;
        else if (wr_stb && wb_adr_i == dis_pkg::OFS_INT_STAT)
            int_stat_reg <= (int_stat_reg & ~wb_dat_i[5:0]) | events;
        else
            int_stat_reg <= int_stat_reg | events;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(int_stat_reg & int_mask_reg);
    end
endmodule

// File: testbench/dis_chk.sv
`timescale 1ns/1ps
// ********
// Port checker
// ********
module dis_chk
(
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Link and status
    input wire logic temp_trip_i,
    input wire logic temp_shutdown_i,
    input wire logic capture_strobe_n_i,
    input wire logic shift_enable_n_i,
    input wire logic chain_out_o,
    input wire logic chain_out_oe_o,
    input wire logic overtemp_flag_n_o,
    input wire logic overtemp_flag_n_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_follow_a: assert property
        (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    ack_cause_a: assert property
        (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    hot_flag_a: assert property
        (temp_trip_i [*5] |-> !overtemp_flag_n_o)
        else $error("hot flag not low");
    hot_clear_a: assert property
        (!temp_trip_i [*5] |-> overtemp_flag_n_o)
        else $error("hot flag low while cool");
    shut_release_a: assert property
        (temp_shutdown_i [*5] |->
        !chain_out_oe_o && !overtemp_flag_n_oe_o)
        else $error("outputs driven in shutdown");
    drive_on_a: assert property
        (!temp_shutdown_i [*5] |->
        chain_out_oe_o && overtemp_flag_n_oe_o)
        else $error("outputs released while cool");
    chain_hold_a: assert property
        ((capture_strobe_n_i && shift_enable_n_i) [*8] |->
        $stable(chain_out_o))
        else $error("serial output moved while held");
endmodule
bind dis_top dis_chk u_dis_chk
(
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
    .temp_trip_i, .temp_shutdown_i, .capture_strobe_n_i,
    .shift_enable_n_i, .chain_out_o, .chain_out_oe_o,
    .overtemp_flag_n_o, .overtemp_flag_n_oe_o
);

// File: testbench/dis_host_model.sv
`timescale 1ns/1ps
// ********
// Host serial port
// ********
module dis_host_model
(
    // Link pins
    output logic capture_strobe_n_o,
    output logic shift_clk_o,
    output logic shift_enable_n_o,
    output logic chain_in_o,
    input wire logic chain_out_i
);
    initial
    begin
        capture_strobe_n_o = 1'b1;
        shift_clk_o = 1'b0;
        shift_enable_n_o = 1'b1;
        chain_in_o = 1'b0;
    end
    // Clock stands still outside frames; hold keeps enable high
    task automatic frame(input int n, input logic hold,
        input logic [15:0] fill, output logic [15:0] got);
        got = 16'h0;
        #3 capture_strobe_n_o = 1'b0;
        #100 capture_strobe_n_o = 1'b1;
        #60 shift_enable_n_o = hold;
        #60;
        for (int i = 0; i < n; i++)
        begin
            got[n-1-i] = chain_out_i;
            chain_in_o = fill[n-1-i];
            #62.5 shift_clk_o = 1'b1;
            #62.5 shift_clk_o = 1'b0;
        end
        #60 shift_enable_n_o = 1'b1;
        chain_in_o = ~chain_in_o;
    endtask
endmodule

// File: testbench/debounced_input_serializer_tb_top.sv
`timescale 1ns/1ps
module debounced_input_serializer_tb_top;
    // ********
    // Signals
    // ********
    typedef struct packed
    {
        logic [7:0] ch;
        logic lo;
        logic hi;
        logic sup;
        logic trip;
        logic [10:0] exp;
    } dis_row_t;
    localparam int LONG = 20;
    localparam int SHORT = 8;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [7:0] field = 8'h00;
    logic lo = 1'b1;
    logic hi = 1'b1;
    logic sup = 1'b0;
    logic trip = 1'b0;
    logic shut = 1'b0;
    logic [31:0] rdat;
    logic ack, strobe_n, sclk, en_n, cin, cout, cout_oe, hot_n, hot_oe, irq;
    logic cout_line;
    logic [15:0] got;
    logic [31:0] q;
    logic [7:0] prev;
    int lim;
    int n_mismatch = 0;
    int samples_checked = 0;
    dis_row_t rows [5] = '{
        '{8'h00, 1'b1, 1'b1, 1'b0, 1'b0, 11'h100},
        '{8'h01, 1'b0, 1'b1, 1'b0, 1'b0, 11'h580},
        '{8'h80, 1'b1, 1'b0, 1'b1, 1'b0, 11'h301},
        '{8'hff, 1'b0, 1'b0, 1'b0, 1'b1, 11'h4ff},
        '{8'ha5, 1'b1, 1'b1, 1'b1, 1'b1, 11'h2a5}
    };
    always #5 clk_i = ~clk_i;
    // Released line shows no stale level
    assign cout_line = cout_oe ? cout : ~cout;
    dis_top #(.DEB_LONG_CYC(LONG), .DEB_SHORT_CYC(SHORT)) u_dis_top
    (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .field_channel_i(field),
        .filter_select_low_i(lo), .filter_select_high_i(hi),
        .low_supply_flag_i(sup), .temp_trip_i(trip),
        .temp_shutdown_i(shut), .capture_strobe_n_i(strobe_n),
        .shift_clk_i(sclk), .shift_enable_n_i(en_n), .chain_in_i(cin),
        .chain_out_o(cout), .chain_out_oe_o(cout_oe),
        .overtemp_flag_n_o(hot_n), .overtemp_flag_n_oe_o(hot_oe),
        .irq_o(irq)
    );
    dis_host_model u_dis_host_model
    (
        .capture_strobe_n_o(strobe_n), .shift_clk_o(sclk),
        .shift_enable_n_o(en_n), .chain_in_o(cin), .chain_out_i(cout_line)
    );
    // ********
    // Tasks
    // ********
    task automatic go(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic check(input string what, input logic [31:0] e,
        input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    // Waits for ack with no assumed latency
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n == 20)
            n_mismatch++;
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic give_verdict;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #300000;
        n_mismatch++;
        give_verdict;
    end
    // ********
    // Sequence
    // ********
    initial
    begin
        go(3);
        check("reset outs", 32'h2, 32'({ack, cout_oe, hot_n, irq}));
        go(2);
        rst_i <= 1'b0;
        go(4);
        xfer(1'b0, dis_pkg::OFS_INT_MASK, 32'h0, q);
        check("mask rst", 32'(dis_pkg::INT_MASK_RST), q);
        xfer(1'b0, dis_pkg::OFS_CTRL, 32'h0, q);
        check("ctrl rst", 32'(dis_pkg::CTRL_RST), q);
        foreach (rows[i])
        begin
            field <= rows[i].ch;
            lo <= rows[i].lo;
            hi <= rows[i].hi;
            sup <= rows[i].sup;
            trip <= rows[i].trip;
            go(40);
            u_dis_host_model.frame(11, 1'b0, 16'h0, got);
            check("word", 32'(rows[i].exp), 32'(got));
            xfer(1'b0, dis_pkg::OFS_CAPTURE, 32'h0, q);
            check("capture", 32'(rows[i].exp), q);
        end
        u_dis_host_model.frame(13, 1'b0, 16'h1800, got);
        check("cascade", 32'({rows[4].exp, 2'b11}), 32'(got));
        u_dis_host_model.frame(4, 1'b1, 16'h0, got);
        check("hold", 32'h0, 32'(got[3:0]));
        field <= 8'h80;
        lo <= 1'b1;
        hi <= 1'b0;
        sup <= 1'b1;
        trip <= 1'b0;
        go(40);
        fork
            u_dis_host_model.frame(11, 1'b0, 16'h0, got);
            begin
                go(30);
                field <= 8'h7f;
                sup <= 1'b0;
            end
        join
        check("frozen", 32'h301, 32'(got[10:0]));
        for (int m = 3; m >= 0; m--)
        begin
            lim = (m == 2) ? SHORT : (m == 1) ? 0 : LONG;
            lo <= m[0];
            hi <= m[1];
            go(40);
            prev = field;
            field <= ~field;
            if (lim > 0)
            begin
                go(lim - 5);
                xfer(1'b0, dis_pkg::OFS_STATE, 32'h0, q);
                check("early", 32'(prev), 32'(q[7:0]));
            end
            go(14);
            xfer(1'b0, dis_pkg::OFS_STATE, 32'h0, q);
            check("settled", {24'h0, ~prev}, 32'(q[7:0]));
        end
        prev = field;
        field <= 8'h3c;
        go(LONG - 6);
        field <= prev;
        go(40);
        xfer(1'b0, dis_pkg::OFS_STATE, 32'h0, q);
        check("glitch", 32'(prev), 32'(q[7:0]));
        // Select override from software: force bypass
        xfer(1'b1, dis_pkg::OFS_CTRL, 32'h3, q);
        prev = field;
        field <= ~field;
        go(6);
        xfer(1'b0, dis_pkg::OFS_STATE, 32'h0, q);
        check("override", {24'h0, ~prev}, 32'(q[7:0]));
        xfer(1'b1, dis_pkg::OFS_CTRL, 32'h0, q);
        xfer(1'b1, dis_pkg::OFS_INT_STAT, 32'h3f, q);
        u_dis_host_model.frame(11, 1'b0, 16'h0, got);
        xfer(1'b1, dis_pkg::OFS_INT_MASK, 32'h3, q);
        go(2);
        check("irq set", 32'h1, 32'(irq));
        xfer(1'b0, dis_pkg::OFS_INT_STAT, 32'h0, q);
        check("stat", 32'h3, q & 32'h3);
        xfer(1'b1, dis_pkg::OFS_INT_STAT, 32'h3, q);
        go(2);
        check("irq clr", 32'h0, 32'(irq));
        xfer(1'b0, dis_pkg::OFS_INT_MASK, 32'h0, q);
        check("mask", 32'h3, q);
        xfer(1'b0, 8'h20, 32'h0, q);
        check("unmapped", 32'h0, q);
        trip <= 1'b1;
        shut <= 1'b1;
        go(6);
        check("shutdown", 32'h0, 32'({cout_oe, hot_oe, hot_n}));
        trip <= 1'b0;
        shut <= 1'b0;
        go(6);
        check("cool", 32'h7, 32'({cout_oe, hot_oe, hot_n}));
        give_verdict;
    end
endmodule
